// File: hw/prds_pkg.sv
/*
 package for the pwm restart, dead-band and steering block: register offsets,
 field positions, reset values and carrier types. assumes one 125 MHz clock.
*/
package prds_pkg;
    localparam logic [2:0] ADDR_DEADBAND = 3'h0;
    localparam logic [2:0] ADDR_STEERING = 3'h1;
    localparam logic [2:0] ADDR_CCPCTRL = 3'h2;
    localparam logic [2:0] ADDR_SHUTDOWN = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam int RESTART_BIT = 7;
    localparam int SYNC_BIT = 4;
    localparam int SDFLAG_BIT = 7;
    localparam int STATUS_OSCFAIL_BIT = 0;
    localparam int STATUS_SDIN_BIT = 1;
    localparam logic [7:0] DEADBAND_RST = 8'h00;
    localparam logic [7:0] STEERING_RST = 8'h01;
    localparam logic [7:0] CCPCTRL_RST = 8'h00;
    localparam logic [7:0] SHUTDOWN_RST = 8'h00;
    localparam logic [7:0] STEERING_WMASK = 8'hDF;
    localparam int INSN_CYCLE_CLKS = 4;
    localparam logic [1:0] CCP_SINGLE_HI = 2'h3;
    localparam logic [1:0] OUTCFG_SINGLE = 2'h0;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } prds_bus_type;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } prds_pins_type;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SHUT = 2'b10
    } prds_state_type;
endpackage

// File: hw/prds_top.sv
/*
 pwm output conditioning: auto-shutdown with auto-restart, dead-band delay on
 rising edges, pulse steering onto four pins. assumes the raw pwm, period start,
 shutdown condition, sleep and clock-fail inputs come from outside, unsynchronised.
*/
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - auto restart only when top bit of dead-band register is one
// - with auto restart, flag follows condition and clears in hardware
// - after shutdown, outputs stay in shutdown state until next period start
// - without auto restart flag stays set until software clears it
// - dead-band delay only on inactive-to-active transitions
// - delay equals count field times four clocks
// - steering only when mode upper bits 11 and output config 00
// - each steering bit routes pwm to its pin, else port control
// - steered pins take polarity from mode field low bits
// - shutdown forces only steered pins in steering mode
// - sync bit zero applies steering immediately after the write
// - sync bit one defers steering to next period start
// - pair field 00 steering, 01 A/B, 10 A/C, 11 A/D
// - steering bit five reads zero, writes ignored
// - sleep freezes all state except registers, input sync, read data and clock-fail flag, and holds pin levels
// - primary idle keeps the unit running unchanged
// - clock failure sets fail flag, unit keeps running on fallback clock
// - shutdown drives pairs A/C and B/D: 00 low, 01 high, 1x tristate
// - shutdown is level sensitive, held while condition present
// - flag writes ignored while condition present
module prds_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // register port
    input wire prds_pkg::prds_bus_type bus_i,
    output logic [7:0] rdata_o,
    // pwm core and system
    input wire logic pwm_raw_i,
    input wire logic period_start_i,
    input wire logic shutdown_cond_i,
    input wire logic sleep_i,
    input wire logic clock_fail_i,
    input wire logic [3:0] port_data_i,
    input wire logic [3:0] port_oe_i,
    // pins
    output prds_pkg::prds_pins_type pins_o
);
    import prds_pkg::*;

    logic [4:0] sync1_q, sync2_q;
    logic pwm_s, per_s, sd_s, slp_s, cf_s;
    logic per_prev_q;
    logic per_pulse;
    logic run;
    logic [7:0] db_q, steer_q, steer_act_q, ccp_q, sdc_q;
    logic osc_fail_q;
    logic flag_q;
    prds_state_type state_q;
    logic [8:0] dly_q;
    logic pwm_prev_q, pwm_del_q;
    logic [7:0] rdata_q;
    prds_pins_type pins_q;

    // two flops on the pwm, period start, shutdown, sleep and clock-fail inputs before use
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {clock_fail_i, sleep_i, shutdown_cond_i, period_start_i, pwm_raw_i};
            sync2_q <= sync1_q;
        end
    end
    assign pwm_s = sync2_q[0];
    assign per_s = sync2_q[1];
    assign sd_s = sync2_q[2];
    assign slp_s = sync2_q[3];
    assign cf_s = sync2_q[4];
    // sleep gates every state update except register writes, input sync, read data and the clock-fail flag; idle is simply not seen here
    assign run = ~slp_s;
    assign per_pulse = run & per_s & ~per_prev_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            per_prev_q <= 1'b0;
        end else if (run) begin
            per_prev_q <= per_s;
        end
    end

    function automatic logic wr_hit(input prds_bus_type b, input logic [2:0] a);
        wr_hit = b.wr & (b.addr == a);
    endfunction

    // register writes; the bus keeps working in sleep so software may still configure
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            db_q <= DEADBAND_RST;
            steer_q <= STEERING_RST;
            ccp_q <= CCPCTRL_RST;
            sdc_q <= SHUTDOWN_RST;
        end else begin
            if (wr_hit(bus_i, ADDR_DEADBAND)) begin
                db_q <= bus_i.wdata;
            end
            if (wr_hit(bus_i, ADDR_STEERING)) begin
                steer_q <= bus_i.wdata & STEERING_WMASK;
            end
            if (wr_hit(bus_i, ADDR_CCPCTRL)) begin
                ccp_q <= bus_i.wdata;
            end
            if (wr_hit(bus_i, ADDR_SHUTDOWN)) begin
                sdc_q <= {1'b0, bus_i.wdata[6:0]};
            end
        end
    end

    // active steering copy: immediate or at the period boundary
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            steer_act_q <= STEERING_RST;
        end else if (run) begin
            if (!steer_q[SYNC_BIT]) begin
                steer_act_q <= steer_q;
            end else if (per_pulse) begin
                steer_act_q <= steer_q;
            end
        end
    end

    // clock-fail flag is sticky; the event wins over a software clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            osc_fail_q <= 1'b0;
        end else if (cf_s) begin
            osc_fail_q <= 1'b1;
        end else if (wr_hit(bus_i, ADDR_STATUS) && !bus_i.wdata[STATUS_OSCFAIL_BIT]) begin
            osc_fail_q <= 1'b0;
        end
    end

    // shutdown flag: condition sets, hardware or software clears
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flag_q <= 1'b0;
        end else if (run) begin
            if (sd_s) begin
                flag_q <= 1'b1;
            end else if (wr_hit(bus_i, ADDR_SHUTDOWN)) begin
                flag_q <= bus_i.wdata[SDFLAG_BIT];
            end else if (db_q[RESTART_BIT]) begin
                flag_q <= 1'b0;
            end
        end
    end

    // outputs leave shutdown only at a period start once the flag is clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= ST_RUN;
        end else if (run) begin
            case (state_q)
                ST_RUN: begin
                    if (sd_s || flag_q) begin
                        state_q <= ST_SHUT;
                    end
                end
                ST_SHUT: begin
                    if (!flag_q && !sd_s && per_pulse) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_SHUT;
                end
            endcase
        end
    end

    // dead band: rising edge waits count*4 clocks, falling edge passes at once
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pwm_prev_q <= 1'b0;
            pwm_del_q <= 1'b0;
            dly_q <= 9'h000;
        end else if (run) begin
            pwm_prev_q <= pwm_s;
            if (!pwm_s) begin
                pwm_del_q <= 1'b0;
                dly_q <= 9'h000;
            end else if (!pwm_prev_q) begin
                if (db_q[6:0] == 7'h00) begin
                    pwm_del_q <= 1'b1;
                end else begin
                    dly_q <= 9'({db_q[6:0], 2'b00}) - 9'h001;
                end
            end else if (dly_q != 9'h000) begin
                dly_q <= dly_q - 9'h001;
            end else begin
                pwm_del_q <= 1'b1;
            end
        end
    end

    // pin mux; outputs are registered and held during sleep
    logic steer_mode;
    logic [3:0] sel;
    logic [3:0] pol;
    logic [1:0] pss_ac, pss_bd;
    prds_pins_type pins_d;
    assign steer_mode = (ccp_q[3:2] == CCP_SINGLE_HI) && (ccp_q[7:6] == OUTCFG_SINGLE);
    assign pss_ac = sdc_q[3:2];
    assign pss_bd = sdc_q[1:0];

    always_comb begin
        case (steer_act_q[7:6])
            2'h1: sel = 4'h3;
            2'h2: sel = 4'h5;
            2'h3: sel = 4'h9;
            default: sel = steer_act_q[3:0];
        endcase
        // low mode bits: bit1 sets A/C active-low, bit0 sets B/D active-low
        pol = {ccp_q[0], ccp_q[1], ccp_q[0], ccp_q[1]};
        pins_d.out = port_data_i;
        pins_d.oe = port_oe_i;
        for (int i = 0; i < 4; i++) begin
            if (steer_mode && sel[i]) begin
                if (state_q == ST_SHUT) begin
                    // only steered pins are forced
                    pins_d.out[i] = (i[0] ? pss_bd[0] : pss_ac[0]);
                    pins_d.oe[i] = ~(i[0] ? pss_bd[1] : pss_ac[1]);
                end else begin
                    pins_d.out[i] = pwm_del_q ^ pol[i];
                    pins_d.oe[i] = port_oe_i[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pins_q <= '0;
        end else if (run) begin
            pins_q <= pins_d;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_DEADBAND: rdata_q <= db_q;
                ADDR_STEERING: rdata_q <= steer_q;
                ADDR_CCPCTRL: rdata_q <= ccp_q;
                ADDR_SHUTDOWN: rdata_q <= {flag_q, sdc_q[6:0]};
                ADDR_STATUS: rdata_q <= {6'h00, sd_s, osc_fail_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o = rdata_q;
    assign pins_o = pins_q;
endmodule
`default_nettype wire

// File: bench/prds_drv_model.sv
/*
 switch driver model on the four pins.
 assumes pull-downs on the pins, so a released pin reads low.
*/
`timescale 1ns/1ps
`default_nettype none
module prds_drv_model (
    // pins from the block
    input wire prds_pkg::prds_pins_type pins_i,
    // level seen by the drivers
    output logic [3:0] level_o
);
    import prds_pkg::*;
    // pull-down wins when released: keeps the power switch off
    assign level_o = pins_i.out & pins_i.oe;
endmodule
`default_nettype wire

// File: bench/prds_top_sva.sv
/*
 port assertions for prds_top, bound below.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module prds_top_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // watched ports
    input wire prds_pkg::prds_bus_type bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic shutdown_cond_i,
    input wire logic sleep_i,
    input wire logic [3:0] port_data_i,
    input wire logic [3:0] port_oe_i,
    input wire prds_pkg::prds_pins_type pins_o
);
    import prds_pkg::*;
    logic steer_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            steer_q <= 1'b0;
        end else if (bus_i.wr && bus_i.addr == ADDR_CCPCTRL) begin
            steer_q <= bus_i.wdata[3:2] == CCP_SINGLE_HI && bus_i.wdata[7:6] == OUTCFG_SINGLE;
        end
    end
    sequence s_read(logic [2:0] a);
        bus_i.rd && bus_i.addr == a;
    endsequence
    // long enough to cover the two-flop input sync
    sequence s_quiet;
        (!sleep_i && !steer_q && !shutdown_cond_i && $stable(port_data_i)
            && $stable(port_oe_i))[*6];
    endsequence
    sequence s_held;
        (shutdown_cond_i && !sleep_i)[*5];
    endsequence
    chk_rd_idle_zero: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not zero when idle");
    chk_steer_bit_five: assert property (s_read(ADDR_STEERING) |=> !rdata_o[5])
        else $error("steering bit five read high");
    chk_unmapped_zero: assert property (bus_i.rd && bus_i.addr > ADDR_STATUS |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_status_upper: assert property (s_read(ADDR_STATUS) |=> rdata_o[7:2] == 6'h00)
        else $error("status upper bits not zero");
    chk_reset_pins: assert property (disable iff (1'b0) srst_i |=> pins_o == '0)
        else $error("pins not cleared by reset");
    chk_sleep_freeze: assert property (sleep_i[*5] |-> $stable(pins_o))
        else $error("pins moved in sleep");
    chk_port_follow: assert property (s_quiet |-> pins_o == {port_data_i, port_oe_i})
        else $error("pins do not follow port control");
    chk_flag_held: assert property (s_held ##0 s_read(ADDR_SHUTDOWN) |=> rdata_o[7])
        else $error("shutdown flag low during shutdown");
endmodule
bind prds_top prds_top_sva chk_u (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .shutdown_cond_i(shutdown_cond_i), .sleep_i(sleep_i),
    .port_data_i(port_data_i), .port_oe_i(port_oe_i), .pins_o(pins_o));
`default_nettype wire

// File: bench/tb_pwm_restart_deadband_steering.sv
/*
 self-checking bench for prds_top with a reference pin model.
 assumes prds_pkg, the driver model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin errors++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module tb_pwm_restart_deadband_steering;
    import prds_pkg::*;
    logic clk_i = 0, srst_i = 1, pwm = 0, pst = 0, sd = 0, slp = 0, cf = 0;
    logic [3:0] pd = 0, po = 0, lvl;
    logic [7:0] rdata, ccp = 0, stv = 8'h01, sdr = 0;
    prds_bus_type bus = '0;
    prds_pins_type pins, hold;
    int errors = 0, comparisons = 0, cyc = 0, n, k, base;
    always #4 clk_i = ~clk_i;
    prds_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
        .pwm_raw_i(pwm), .period_start_i(pst), .shutdown_cond_i(sd), .sleep_i(slp),
        .clock_fail_i(cf), .port_data_i(pd), .port_oe_i(po), .pins_o(pins));
    prds_drv_model drv_u (.pins_i(pins), .level_o(lvl));
    task automatic cy(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        bus <= '0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_i);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus <= '0;
        @(negedge clk_i);
        `CHK("rdata", e, rdata)
    endtask
    task automatic pstart;
        @(posedge clk_i);
        pst <= 1'b1;
        cy(4);
        pst <= 1'b0;
        cy(8);
    endtask
    // reference: steered pins carry pwm with pair polarity, the rest port control
    task automatic chkp(input logic shut);
        prds_pins_type e;
        logic [3:0] m;
        logic [1:0] st;
        @(negedge clk_i);
        m = (ccp[3:2] == CCP_SINGLE_HI && ccp[7:6] == OUTCFG_SINGLE) ?
            (stv[7:6] == 2'h0 ? stv[3:0] : 4'h1 | (4'h1 << stv[7:6])) : 4'h0;
        for (int i = 0; i < 4; i++) begin
            st = i[0] ? sdr[1:0] : sdr[3:2];
            e.out[i] = (shut && m[i]) ? st[0] : m[i] ? pwm ^ ccp[!i[0]] : pd[i];
            e.oe[i] = (shut && m[i]) ? !st[1] : po[i];
        end
        `CHK("pins", e, pins)
        `CHK("level", e.out & e.oe, lvl)
    endtask
    task automatic meas(input logic v, output int c);
        @(posedge clk_i);
        pwm <= v;
        c = 0;
        while (pins.out[0] !== v && c < 1000) begin
            @(negedge clk_i);
            c++;
        end
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            finish_test;
        end
    end
    initial begin
        n = $urandom(31);
        cy(4);
        srst_i <= 1'b0;
        rd(ADDR_STEERING, STEERING_RST);
        rd(ADDR_CCPCTRL, CCPCTRL_RST);
        rd(ADDR_SHUTDOWN, SHUTDOWN_RST);
        rd(ADDR_STATUS, 8'h00);
        n = $urandom;
        wr(ADDR_STEERING, 8'(n));
        rd(ADDR_STEERING, 8'(n) & STEERING_WMASK);
        wr(3'h5 | 3'(n[1:0]), 8'hFF);
        rd(3'h5 | 3'(n[1:0]), 8'h00);
        rd(ADDR_DEADBAND, DEADBAND_RST);
        for (int i = 0; i < 20; i++) begin
            ccp = {2'(i / 16), 2'h0, (i % 8 == 7) ? 2'h1 : 2'h3, 2'(i)};
            stv = 8'($urandom) & 8'hCF;
            wr(ADDR_CCPCTRL, ccp);
            wr(ADDR_STEERING, stv);
            @(posedge clk_i);
            {pwm, pd, po} <= 9'($urandom);
            cy(8);
            chkp(1'b0);
        end
        ccp = 8'h0C;
        stv = 8'h11;
        wr(ADDR_CCPCTRL, ccp);
        wr(ADDR_STEERING, stv);
        pstart;
        wr(ADDR_STEERING, 8'h12);
        cy(8);
        chkp(1'b0);
        stv = 8'h12;
        pstart;
        chkp(1'b0);
        stv = 8'h01;
        wr(ADDR_STEERING, stv);
        meas(1'b0, k);
        meas(1'b1, base);
        meas(1'b0, k);
        `CHK("fall0", base, k)
        n = 1 + $urandom % 8;
        wr(ADDR_DEADBAND, 8'(n));
        meas(1'b1, k);
        `CHK("rise", base + 4 * n, k)
        meas(1'b0, k);
        `CHK("fall", base, k)
        wr(ADDR_DEADBAND, 8'h00);
        stv = 8'h03;
        sdr = 8'h06;
        wr(ADDR_STEERING, stv);
        wr(ADDR_SHUTDOWN, sdr);
        sd <= 1'b1;
        cy(6);
        chkp(1'b1);
        wr(ADDR_SHUTDOWN, sdr);
        rd(ADDR_SHUTDOWN, 8'h86);
        sd <= 1'b0;
        cy(6);
        rd(ADDR_SHUTDOWN, 8'h86);
        wr(ADDR_SHUTDOWN, sdr);
        cy(4);
        chkp(1'b1);
        pstart;
        chkp(1'b0);
        wr(ADDR_DEADBAND, 8'h80);
        sd <= 1'b1;
        cy(6);
        sd <= 1'b0;
        cy(6);
        rd(ADDR_SHUTDOWN, 8'h06);
        chkp(1'b1);
        pstart;
        chkp(1'b0);
        slp <= 1'b1;
        cy(6);
        hold = pins;
        pwm <= ~pwm;
        cy(8);
        `CHK("sleep", hold, pins)
        slp <= 1'b0;
        cy(8);
        chkp(1'b0);
        cf <= 1'b1;
        cy(3);
        cf <= 1'b0;
        cy(4);
        rd(ADDR_STATUS, 8'h01);
        wr(ADDR_STATUS, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        finish_test;
    end
endmodule
`default_nettype wire
